/* include/sbtc_cfg.svh */
// Summary of operation
// - count only while run enable is set
// - internal source counts once per instruction cycle
// - external source counts rising edges of pin
// - sync bypass bit picks synchronised or raw
// - wide mode maps high address to buffer
// - low read in wide mode copies high
// - low write in wide mode loads high
// - wide mode: high byte only via buffer
// - low byte write, or trigger outside async external mode, clears prescaler
// - status flag shows aux-clocked system
// - oscillator enable bit runs aux oscillator
// - enabled counter forces pins input, reads zero
// - aux oscillator keeps running in power modes
// - clock select 01 runs system from aux
// - config bit selects low-power oscillator level
// - count wraps ffff to 0, sets flag
// - trigger clears count except in async external mode, writes win over it
`ifndef SBTC_CFG_SVH
`define SBTC_CFG_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define SBTC_ADR_CONTROL 8'h00
`define SBTC_ADR_LOW 8'h04
`define SBTC_ADR_HIGH 8'h08
`define SBTC_ADR_CLKSEL 8'h0c
`define SBTC_ADR_STATUS 8'h10

// -----------------------------------------------------------------
// control field positions and reset values
// -----------------------------------------------------------------
`define SBTC_BIT_RUN 0
`define SBTC_BIT_SRC 1
`define SBTC_BIT_SYNCB 2
`define SBTC_BIT_OSCEN 3
`define SBTC_BIT_PS_LO 4
`define SBTC_BIT_PS_HI 5
`define SBTC_BIT_STAT 6
`define SBTC_BIT_WIDE 7
`define SBTC_BIT_OVF 0
`define SBTC_CONTROL_RST 8'h00
`define SBTC_CONTROL_WMASK 8'hbf
`define SBTC_CLKSEL_RST 2'h0
`define SBTC_CLKSEL_AUX 2'h1
`define SBTC_COUNT_RST 16'h0000
`define SBTC_COUNT_MAX 16'hffff

// -----------------------------------------------------------------
// timing: instruction cycle is four oscillator clocks
// -----------------------------------------------------------------
`define SBTC_INSTR_LAST 2'h3

`endif

/* include/sbtc_pkg.sv */
`default_nettype none

package sbtc_pkg;

   // one wishbone request as seen by the slave
   typedef struct packed {
      logic [7:0] adr;
      logic we;
      logic [3:0] sel;
      logic [31:0] dat;
   } sbtc_wb_req_t;

   // bus slave handshake states
   typedef enum logic [1:0] {
      SBTC_BUS_IDLE = 2'b01,
      SBTC_BUS_ACK = 2'b10
   } sbtc_bus_state_t;

endpackage

`default_nettype wire

/* rtl/sbtc_prescale.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_cfg.svh"

// input prescaler: passes one of every 1, 2, 4 or 8 pulses
module sbtc_prescale (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic clr_i,
   input wire logic [1:0] sel_i,
   input wire logic pulse_i,
   output logic tick_o
);

   logic [2:0] cnt_reg;

   // last count value before a tick for each ratio code
   function automatic logic [2:0] ratio_last(input logic [1:0] sel);
      unique case (sel)
         2'h0: ratio_last = 3'h0;
         2'h1: ratio_last = 3'h1;
         2'h2: ratio_last = 3'h3;
         2'h3: ratio_last = 3'h7;
      endcase
   endfunction

   // tick on the pulse that completes the ratio
   assign tick_o = pulse_i & (cnt_reg >= ratio_last(sel_i)) & ~clr_i;

   // count pulses, wrap at the ratio, clear on request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= 3'h0;
      end else if (clr_i) begin
         cnt_reg <= 3'h0;
      end else if (tick_o) begin
         cnt_reg <= 3'h0;
      end else if (pulse_i) begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_clear_zero: assert property (clr_i |=> cnt_reg == 3'h0) else $error("prescaler not cleared");
   a_div_eight: assert property (sel_i == 2'h3 && tick_o |-> cnt_reg == 3'h7) else $error("divide by 8 wrong");
   a_div_two: assert property (sel_i == 2'h1 && pulse_i && !clr_i && cnt_reg == 3'h0 |-> !tick_o)
      else $error("divide by 2 ticked early");

endmodule

`default_nettype wire

/* rtl/sbtc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for the two oscillator / count pins
module sbtc_sync (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] pins_i,
   output logic [1:0] pins_o
);

   logic [1:0] meta_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= 2'h0;
         pins_o <= 2'h0;
      end else begin
         meta_reg <= pins_i;
         pins_o <= meta_reg;
      end
   end

endmodule

`default_nettype wire

/* rtl/sbtc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_cfg.svh"

// 16-bit timer / counter with wishbone register access
module sbtc_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire logic aux_osc_input_pin_i,
   input wire logic external_count_input_i,
   input wire logic special_event_i,
   input wire logic sleep_i,
   input wire logic aux_osc_low_power_cfg_i,
   input wire logic [1:0] port_c_direction_i,
   output logic aux_osc_output_pin_o,
   output logic aux_osc_output_pin_oe_n_o,
   output logic aux_osc_low_power_o,
   output logic sysclk_from_aux_o,
   output logic overflow_flag_o,
   output logic [1:0] port_c_read_o,
   output logic [1:0] port_c_oe_n_o
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   sbtc_pkg::sbtc_wb_req_t req;
   sbtc_pkg::sbtc_bus_state_t bus_state_reg;
   logic bus_go;
   logic wr_lane;
   logic rd_go;
   logic wr_ctrl;
   logic wr_low;
   logic wr_high;
   logic wr_clksel;
   logic clr_ovf;
   logic [7:0] control_reg;
   logic [1:0] clksel_reg;
   logic [15:0] cnt_reg;
   logic [7:0] buf_reg;
   logic [1:0] instr_cnt_reg;
   logic instr_en;
   logic [1:0] pins_q;
   logic src_pin;
   logic src_prev_reg;
   logic rise;
   logic pending_reg;
   logic pulse;
   logic tick;
   logic trig_eff;
   logic inc_take;
   logic ovf_set;
   logic run;
   logic ext_src;
   logic bypass;
   logic wide;
   logic [31:0] rd_data;

   // match a word-aligned register offset
   function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
      reg_hit = (adr[7:2] == off[7:2]);
   endfunction

   // -----------------------------------------------------------------
   // wishbone slave
   // -----------------------------------------------------------------
   assign req = {wb_adr_i, wb_we_i, wb_sel_i, wb_dat_i};
   assign bus_go = (bus_state_reg == sbtc_pkg::SBTC_BUS_IDLE) & wb_cyc_i & wb_stb_i;
   assign wr_lane = bus_go & req.we & req.sel[0];
   assign rd_go = bus_go & ~req.we;
   assign wr_ctrl = wr_lane & reg_hit(req.adr, `SBTC_ADR_CONTROL);
   assign wr_low = wr_lane & reg_hit(req.adr, `SBTC_ADR_LOW);
   assign wr_high = wr_lane & reg_hit(req.adr, `SBTC_ADR_HIGH);
   assign wr_clksel = wr_lane & reg_hit(req.adr, `SBTC_ADR_CLKSEL);
   assign clr_ovf = wr_lane & reg_hit(req.adr, `SBTC_ADR_STATUS) & req.dat[`SBTC_BIT_OVF];

   // one ack per request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_reg <= sbtc_pkg::SBTC_BUS_IDLE;
      end else begin
         unique case (bus_state_reg)
            sbtc_pkg::SBTC_BUS_IDLE: begin
               if (bus_go) begin
                  bus_state_reg <= sbtc_pkg::SBTC_BUS_ACK;
               end
            end
            sbtc_pkg::SBTC_BUS_ACK: begin
               bus_state_reg <= sbtc_pkg::SBTC_BUS_IDLE;
            end
            default: begin
               bus_state_reg <= sbtc_pkg::SBTC_BUS_IDLE;
            end
         endcase
      end
   end

   // ack flop mirrors the accepting edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_go;
      end
   end

   // read mux; high address goes to buffer in wide mode
   always_comb begin
      rd_data = 32'h0;
      if (reg_hit(req.adr, `SBTC_ADR_CONTROL)) begin
         rd_data[7:0] = {control_reg[7], sysclk_from_aux_o, control_reg[5:0]};
      end else if (reg_hit(req.adr, `SBTC_ADR_LOW)) begin
         rd_data[7:0] = cnt_reg[7:0];
      end else if (reg_hit(req.adr, `SBTC_ADR_HIGH)) begin
         rd_data[7:0] = wide ? buf_reg : cnt_reg[15:8];
      end else if (reg_hit(req.adr, `SBTC_ADR_CLKSEL)) begin
         rd_data[1:0] = clksel_reg;
      end else if (reg_hit(req.adr, `SBTC_ADR_STATUS)) begin
         rd_data[`SBTC_BIT_OVF] = overflow_flag_o;
      end
   end

   // read data captured on the accepting edge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (rd_go) begin
         wb_dat_o <= rd_data;
      end
   end

   // -----------------------------------------------------------------
   // control and clock select registers
   // -----------------------------------------------------------------
   assign run = control_reg[`SBTC_BIT_RUN];
   assign ext_src = control_reg[`SBTC_BIT_SRC];
   assign bypass = control_reg[`SBTC_BIT_SYNCB];
   assign wide = control_reg[`SBTC_BIT_WIDE];

   // status bit is read-only and never stored
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         control_reg <= `SBTC_CONTROL_RST;
      end else if (wr_ctrl) begin
         control_reg <= req.dat[7:0] & `SBTC_CONTROL_WMASK;
      end
   end

   // system clock source select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clksel_reg <= `SBTC_CLKSEL_RST;
      end else if (wr_clksel) begin
         clksel_reg <= req.dat[1:0];
      end
   end

   // system runs from aux oscillator when select is 01
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sysclk_from_aux_o <= 1'b0;
      end else begin
         sysclk_from_aux_o <= (clksel_reg == `SBTC_CLKSEL_AUX);
      end
   end

   // -----------------------------------------------------------------
   // count sources
   // -----------------------------------------------------------------
   sbtc_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pins_i({external_count_input_i, aux_osc_input_pin_i}),
      .pins_o(pins_q)
   );

   // instruction cycle enable, stopped in sleep
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         instr_cnt_reg <= 2'h0;
      end else begin
         instr_cnt_reg <= instr_cnt_reg + 2'h1;
      end
   end
   assign instr_en = (instr_cnt_reg == `SBTC_INSTR_LAST) & ~sleep_i;

   // oscillator input when enabled, else external count pin
   assign src_pin = control_reg[`SBTC_BIT_OSCEN] ? pins_q[0] : pins_q[1];

   // rising edge detector on the selected pin
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_prev_reg <= 1'b0;
      end else begin
         src_prev_reg <= src_pin;
      end
   end
   assign rise = src_pin & ~src_prev_reg;

   // synchronised mode holds an edge until the next instruction cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pending_reg <= 1'b0;
      end else begin
         pending_reg <= rise | (pending_reg & ~instr_en);
      end
   end

   // pick the count pulse for the selected mode
   assign pulse = run & (ext_src ? (bypass ? rise : (pending_reg & instr_en)) : instr_en);

   sbtc_prescale u_prescale (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clr_i(wr_low | trig_eff),
      .sel_i(control_reg[`SBTC_BIT_PS_HI:`SBTC_BIT_PS_LO]),
      .pulse_i(pulse),
      .tick_o(tick)
   );

   // -----------------------------------------------------------------
   // counter, high byte buffer, overflow flag
   // -----------------------------------------------------------------
   assign trig_eff = special_event_i & ~(ext_src & bypass);
   assign inc_take = tick & ~wr_low & ~(wr_high & ~wide) & ~trig_eff;
   assign ovf_set = inc_take & (cnt_reg == `SBTC_COUNT_MAX);

   // writes beat the trigger, the trigger beats counting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= `SBTC_COUNT_RST;
      end else if (wr_low) begin
         cnt_reg <= {wide ? buf_reg : cnt_reg[15:8], req.dat[7:0]};
      end else if (wr_high & ~wide) begin
         cnt_reg[15:8] <= req.dat[7:0];
      end else if (trig_eff) begin
         cnt_reg <= `SBTC_COUNT_RST;
      end else if (inc_take) begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   // in wide mode, buffer takes high writes and snapshots on low reads
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         buf_reg <= 8'h00;
      end else if (wr_high & wide) begin
         buf_reg <= req.dat[7:0];
      end else if (rd_go & wide & reg_hit(req.adr, `SBTC_ADR_LOW)) begin
         buf_reg <= cnt_reg[15:8];
      end
   end

   // sticky overflow, write 1 clears, set wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         overflow_flag_o <= 1'b0;
      end else begin
         overflow_flag_o <= ovf_set | (overflow_flag_o & ~clr_ovf);
      end
   end

   // -----------------------------------------------------------------
   // pins and oscillator control
   // -----------------------------------------------------------------
   // oscillator amplifier runs on its enable alone, not on sleep
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         aux_osc_output_pin_o <= 1'b0;
         aux_osc_output_pin_oe_n_o <= 1'b1;
         aux_osc_low_power_o <= 1'b0;
      end else begin
         aux_osc_output_pin_o <= control_reg[`SBTC_BIT_OSCEN] & ~pins_q[0];
         aux_osc_output_pin_oe_n_o <= ~control_reg[`SBTC_BIT_OSCEN];
         aux_osc_low_power_o <= aux_osc_low_power_cfg_i;
      end
   end

   // enabled counter forces both pins to inputs reading zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_c_read_o <= 2'h0;
         port_c_oe_n_o <= 2'h3;
      end else begin
         port_c_read_o <= run ? 2'h0 : pins_q;
         port_c_oe_n_o <= run ? 2'h3 : port_c_direction_i;
      end
   end

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_hold_off: assert property (!run && !wr_lane && !trig_eff |=> $stable(cnt_reg))
      else $error("count moved while stopped");
   a_internal_rate: assert property (run && !ext_src && control_reg[5:4] == 2'h0 && instr_en && !wr_lane
      && !special_event_i |=> cnt_reg == $past(cnt_reg) + 16'h0001) else $error("internal tick missed");
   a_async_edge: assert property (run && ext_src && bypass && rise && control_reg[5:4] == 2'h0 && !wr_lane
      |=> cnt_reg == $past(cnt_reg) + 16'h0001) else $error("external edge missed");
   a_wide_read_copy: assert property (rd_go && wide && reg_hit(req.adr, `SBTC_ADR_LOW)
      |=> buf_reg == $past(cnt_reg[15:8])) else $error("high byte not snapshotted");
   a_wide_write_load: assert property (wr_low && wide
      |=> cnt_reg == {$past(buf_reg), $past(wb_dat_i[7:0])}) else $error("16-bit write wrong");
   a_wrap_flag: assert property (inc_take && cnt_reg == `SBTC_COUNT_MAX
      |=> cnt_reg == `SBTC_COUNT_RST && overflow_flag_o) else $error("wrap or flag wrong");
   a_write_beats_trig: assert property (wr_low && special_event_i && !wide
      |=> cnt_reg[7:0] == $past(wb_dat_i[7:0])) else $error("trigger beat write");
   a_pins_read_zero: assert property (run |=> port_c_read_o == 2'h0 && port_c_oe_n_o == 2'h3)
      else $error("pins not forced to input");
   a_status_flag: assert property (clksel_reg == `SBTC_CLKSEL_AUX |=> sysclk_from_aux_o)
      else $error("clock status flag missing");

   c_overflow: cover property (ovf_set);
   c_wide_read: cover property (rd_go && wide && reg_hit(req.adr, `SBTC_ADR_LOW));
   c_trigger: cover property (trig_eff && run);

endmodule

`default_nettype wire

/* verif/sbtc_src_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far side: crystal on one pin, external count clock on the other
module sbtc_src_model (
   input wire logic clk_i,
   input wire logic hold_i,
   output logic aux_o,
   output logic ext_o
);
   logic aux_line;
   logic ext_line;

   // -----------------------------------------------------------------
   // pin levels
   // -----------------------------------------------------------------
   // both lines rest low between bursts; hold forces them high
   initial begin
      aux_line = 1'b0;
      ext_line = 1'b0;
   end
   assign aux_o = aux_line | hold_i;
   assign ext_o = ext_line | hold_i;

   // burst of n rising edges, eight clocks a period, on one pin
   task automatic pulses(input logic on_aux, input int n);
      for (int i = 0; i < n; i++) begin
         if (on_aux) aux_line <= 1'b1;
         else ext_line <= 1'b1;
         repeat (4) @(posedge clk_i);
         aux_line <= 1'b0;
         ext_line <= 1'b0;
         repeat (4) @(posedge clk_i);
      end
   endtask
endmodule

`default_nettype wire

/* verif/sbtc_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_cfg.svh"

module sbtc_tb_top;
   localparam logic [7:0] a_ctl = `SBTC_ADR_CONTROL;
   localparam logic [7:0] a_lo = `SBTC_ADR_LOW;
   localparam logic [7:0] a_hi = `SBTC_ADR_HIGH;
   localparam logic [7:0] a_cs = `SBTC_ADR_CLKSEL;
   localparam logic [7:0] a_st = `SBTC_ADR_STATUS;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic aux_pin, ext_pin, special_event_i, sleep_i, lp_cfg, hold;
   logic [1:0] port_c_direction_i, port_c_read_o, port_c_oe_n_o;
   logic osc_out, osc_oe_n, lp_out, sysclk_aux, ovf;
   int fails = 0;
   int cmp_count = 0;

   sbtc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .aux_osc_input_pin_i(aux_pin),
      .external_count_input_i(ext_pin), .special_event_i(special_event_i), .sleep_i(sleep_i),
      .aux_osc_low_power_cfg_i(lp_cfg), .port_c_direction_i(port_c_direction_i),
      .aux_osc_output_pin_o(osc_out), .aux_osc_output_pin_oe_n_o(osc_oe_n),
      .aux_osc_low_power_o(lp_out), .sysclk_from_aux_o(sysclk_aux), .overflow_flag_o(ovf),
      .port_c_read_o(port_c_read_o), .port_c_oe_n_o(port_c_oe_n_o));
   sbtc_src_model src (.clk_i(clk_i), .hold_i(hold), .aux_o(aux_pin), .ext_o(ext_pin));

   // -----------------------------------------------------------------
   // clock and checking helpers
   // -----------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      chk8({7'h00, got}, {7'h00, exp}, what);
   endtask
   // one classic wishbone cycle; holds the request until ack is sampled
   task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1);
      chk8(n[7:0], 8'h02, "ack one cycle after take");
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      chk8(q, exp, "register read");
   endtask
   // count gained over 64 clocks between two taking edges
   task automatic span(input logic [7:0] exp);
      logic [7:0] x, y;
      bus(1'b0, a_lo, 8'h00, x);
      repeat (61) @(posedge clk_i);
      bus(1'b0, a_lo, 8'h00, y);
      chk8(y - x, exp, "internal count span");
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d, comparisons %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      rchk(a_ctl, 8'h00);
      rchk(a_lo, 8'h00);
      rchk(a_hi, 8'h00);
      rchk(a_cs, 8'h00);
      rchk(a_st, 8'h00);
      wr(8'h14, 8'hff);
      rchk(8'h14, 8'h00);
      wr(a_ctl, 8'h40);
      rchk(a_ctl, 8'h00);
   endtask
   task automatic t_internal();
      wr(a_ctl, 8'h01);
      span(8'h10);
      wr(a_ctl, 8'h05);
      span(8'h10);
      wr(a_ctl, 8'h21);
      span(8'h04);
      wr(a_ctl, 8'h20);
      span(8'h00);
   endtask
   task automatic t_external();
      logic [7:0] c;
      for (int p = 0; p < 4; p++) begin
         c = {2'b00, p[1:0], 1'b0, p[0], 2'b10};
         wr(a_lo, 8'h00);
         wr(a_ctl, c);
         wr(a_ctl, c | 8'h01);
         src.pulses(1'b0, 16);
         repeat (8) @(posedge clk_i);
         wr(a_ctl, c);
         rchk(a_lo, 8'h10 >> p);
      end
      // in sleep only the unsynchronised counter sees crystal edges
      sleep_i <= 1'b1;
      wr(a_lo, 8'h00);
      wr(a_ctl, 8'h0e);
      repeat (20) @(posedge clk_i);
      @(negedge clk_i);
      chk1(osc_oe_n, 1'b0, "osc pin enable");
      chk1(osc_out, 1'b1, "osc drive");
      wr(a_ctl, 8'h0f);
      src.pulses(1'b1, 8);
      repeat (8) @(posedge clk_i);
      wr(a_ctl, 8'h0e);
      rchk(a_lo, 8'h08);
      sleep_i <= 1'b0;
      wr(a_ctl, 8'h00);
      repeat (3) @(negedge clk_i);
      chk1(osc_oe_n, 1'b1, "osc pin off");
   endtask
   task automatic t_prescale_clear();
      wr(a_lo, 8'h00);
      wr(a_ctl, 8'h37);
      for (int k = 0; k < 2; k++) begin
         src.pulses(1'b0, 4);
         repeat (8) @(posedge clk_i);
         wr(k ? a_lo : a_hi, 8'h00);
         src.pulses(1'b0, 4);
         repeat (8) @(posedge clk_i);
         rchk(a_lo, k ? 8'h00 : 8'h01);
         wr(a_lo, 8'h00);
      end
      wr(a_ctl, 8'h00);
   endtask
   task automatic t_wide();
      wr(a_hi, 8'h55);
      wr(a_lo, 8'h66);
      rchk(a_hi, 8'h55);
      wr(a_ctl, 8'h80);
      wr(a_hi, 8'hab);
      rchk(a_hi, 8'hab);
      wr(a_lo, 8'hcd);
      wr(a_ctl, 8'h00);
      rchk(a_hi, 8'hab);
      rchk(a_lo, 8'hcd);
      wr(a_hi, 8'h77);
      wr(a_ctl, 8'h80);
      rchk(a_hi, 8'hab);
      rchk(a_lo, 8'hcd);
      rchk(a_hi, 8'h77);
      wr(a_ctl, 8'h00);
   endtask
   task automatic t_overflow_trigger();
      wr(a_hi, 8'hff);
      wr(a_lo, 8'hfe);
      wr(a_ctl, 8'h06);
      wr(a_ctl, 8'h07);
      for (int k = 0; k < 2; k++) begin
         src.pulses(1'b0, 1);
         repeat (8) @(negedge clk_i);
         chk1(ovf, k[0], "overflow flag");
      end
      rchk(a_hi, 8'h00);
      rchk(a_st, 8'h01);
      wr(a_st, 8'h01);
      @(negedge clk_i);
      chk1(ovf, 1'b0, "flag cleared");
      wr(a_ctl, 8'h02);
      wr(a_hi, 8'h12);
      wr(a_lo, 8'h34);
      wr(a_ctl, 8'h03);
      @(posedge clk_i);
      special_event_i <= 1'b1;
      @(posedge clk_i);
      special_event_i <= 1'b0;
      rchk(a_hi, 8'h00);
      fork
         wr(a_lo, 8'h55);
         begin
            @(posedge clk_i);
            special_event_i <= 1'b1;
            @(posedge clk_i);
            special_event_i <= 1'b0;
         end
      join
      rchk(a_lo, 8'h55);
      wr(a_ctl, 8'h00);
   endtask
   task automatic t_clock_pins();
      for (int v = 0; v < 4; v++) begin
         wr(a_cs, v[7:0]);
         @(negedge clk_i);
         chk1(sysclk_aux, v == 1, "aux system clock");
         rchk(a_ctl, (v == 1) ? 8'h40 : 8'h00);
      end
      lp_cfg <= 1'b1;
      repeat (3) @(negedge clk_i);
      chk1(lp_out, 1'b1, "low power level");
      @(posedge clk_i);
      hold <= 1'b1;
      port_c_direction_i <= 2'b10;
      repeat (4) @(negedge clk_i);
      chk8({6'h00, port_c_read_o}, 8'h03, "port read idle");
      chk8({6'h00, port_c_oe_n_o}, 8'h02, "port dir idle");
      wr(a_ctl, 8'h01);
      repeat (2) @(negedge clk_i);
      chk8({6'h00, port_c_read_o}, 8'h00, "port read run");
      chk8({6'h00, port_c_oe_n_o}, 8'h03, "port dir run");
      wr(a_ctl, 8'h00);
      hold <= 1'b0;
   endtask

   // -----------------------------------------------------------------
   // main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      {wb_cyc_i, wb_stb_i, wb_we_i, special_event_i, sleep_i, lp_cfg, hold} = 7'h00;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      port_c_direction_i = 2'b11;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_internal();
      t_external();
      t_prescale_clear();
      t_wide();
      t_overflow_trigger();
      t_clock_pins();
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      report_and_stop();
   end
endmodule

`default_nettype wire
